// ### rtl/utw_pkg.sv
// shared constants and types of the up-counter timer with event and window modes
package utw_pkg;
	// register byte offsets on the bus
	localparam logic [7:0]  OFF_CTRL      = 8'h00;
	localparam logic [7:0]  OFF_CMP_LO    = 8'h04;
	localparam logic [7:0]  OFF_CMP_HI    = 8'h08;
	localparam logic [7:0]  OFF_CAP_LO    = 8'h0C;
	localparam logic [7:0]  OFF_CAP_HI    = 8'h10;
	localparam logic [7:0]  OFF_CNT_LO    = 8'h14;
	localparam logic [7:0]  OFF_CNT_HI    = 8'h18;
	localparam logic [7:0]  OFF_STATUS    = 8'h1C;
	// control register field positions
	localparam int          CTL_MODE_LSB  = 0;
	localparam int          CTL_CLK_LSB   = 2;
	localparam int          CTL_START_LSB = 4;
	localparam int          CTL_STOPSEL   = 6;
	localparam int          CTL_ACAP      = 7;
	localparam int          CTL_PSEL      = 8;
	localparam int          CTL_WIDTH     = 9;
	// status register field positions
	localparam int          STS_RUN       = 0;
	localparam int          STS_WAIT      = 1;
	localparam int          STS_PEND      = 2;
	// reset values
	localparam logic [8:0]  CTRL_RESET    = 9'h000;
	localparam logic [15:0] CMP_RESET     = 16'hFFFF;
	// field encodings
	localparam logic [1:0]  MODE_BASE     = 2'h0;
	localparam logic [1:0]  MODE_WINDOW   = 2'h1;
	localparam logic [1:0]  START_STOP    = 2'h0;
	localparam logic [1:0]  START_CMD     = 2'h1;
	localparam logic [1:0]  START_RISE    = 2'h2;
	localparam logic [1:0]  START_FALL    = 2'h3;
	localparam logic [1:0]  CLK_DIV11     = 2'h0;
	localparam logic [1:0]  CLK_DIV7      = 2'h1;
	localparam logic [1:0]  CLK_DIV3      = 2'h2;
	localparam logic [1:0]  CLK_PIN       = 2'h3;
	// pin filter timing, in periods of the high-speed clock (hclk)
	localparam int          FILT_REJECT_FC = 4;
	localparam int          FILT_DETECT_FC = 12;
	localparam int          FILT_SYNC_FC   = 2;
	localparam logic [2:0]  FILT_STABLE    = 3'((FILT_REJECT_FC + FILT_DETECT_FC) / 2
		- FILT_SYNC_FC);
	// counter sequencing states
	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_RUN} utw_state_t;
endpackage : utw_pkg

// ### rtl/utw_prescaler.sv
// free-running divider giving the internal source clock enables
module utw_prescaler (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic slow_tick_in,
	output logic      tick_fc3,
	output logic      tick_fc7,
	output logic      tick_fc11,
	output logic      tick_fs3
);
	logic [10:0] div;
	logic [2:0]  sdiv;

	// high-speed divide chain and low-speed divide by eight
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			div       <= 11'h000;
			sdiv      <= 3'h0;
			tick_fc3  <= 1'b0;
			tick_fc7  <= 1'b0;
			tick_fc11 <= 1'b0;
			tick_fs3  <= 1'b0;
		end
		else
		begin
			div       <= div + 11'h001;
			tick_fc3  <= &div[2:0];
			tick_fc7  <= &div[6:0];
			tick_fc11 <= &div;
			if (slow_tick_in)
				sdiv <= sdiv + 3'h1;
			tick_fs3  <= slow_tick_in && (&sdiv);
		end
	end
endmodule : utw_prescaler

// ### rtl/utw_pin_filter.sv
// count input pin synchroniser, noise filter and edge detector
module utw_pin_filter (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic pin_in,
	input  wire logic bypass,
	output logic      level,
	output logic      rise,
	output logic      fall
);
	logic       sync1;
	logic       sync2;
	logic [2:0] cnt;
	wire        differ = sync2 != level;
	wire        accept = differ && (bypass || cnt == (utw_pkg::FILT_STABLE - 3'h1)); // see (R10) (R11)

	// two-flop synchroniser, then hold-off counter on the settled level
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			cnt   <= 3'h0;
			level <= 1'b0;
			rise  <= 1'b0;
			fall  <= 1'b0;
		end
		else
		begin
			sync1 <= pin_in;
			sync2 <= sync1;
			cnt   <= (differ && !accept) ? cnt + 3'h1 : 3'h0; // see (R10)
			if (accept)
				level <= sync2;
			rise  <= accept && sync2;
			fall  <= accept && !sync2;
		end
	end

	filt_reject_a: assert property (@(posedge hclk) disable iff (!hresetn) // see (R10)
		($changed(level) && !$past(bypass)) |-> ($past(sync2, 1) == level) && ($past(sync2, 6) == level))
		else $error("pin filter passed a short pulse");
endmodule : utw_pin_filter

// ### rtl/utw_timer.sv
// 16-bit up-counter timer: timer, trigger, event and window modes, AHB-Lite registers
// How it works
// (R1) timer mode counts source ticks; compare A match interrupts, clears, keeps counting
// (R2) with auto-capture on, each source tick copies the count into capture B
// (R3) capture B only updates while running with capture on; read before stopping
// (R4) software waits one source tick after enabling capture before first read
// (R5) trigger mode starts counting only after the selected pin edge
// (R6) stop-select set: match clears, halts and interrupts
// (R7) stop-select set: opposite edge before match clears and halts, no interrupt
// (R8) halted trigger counter restarts from zero on the next trigger edge
// (R9) stop-select clear: match clears, halts, interrupts; other edges ignored while running
// (R10) pin filter drops pulses up to 4 fc periods, keeps 12 or more
// (R11) low-frequency run and sleep bypass the pin filter
// (R12) event mode counts selected pin edges instead of internal ticks
// (R13) event mode checks match on the opposite edge, then clears and interrupts
// (R14) auto-capture also works in event mode
// (R15) window mode counts internal ticks while pin is at chosen level
// (R16) window pulse must be much slower than the internal source clock
// (R17) clock select: 00 /2^11 or slow/8, 01 /2^7, 10 /2^3, 11 pin
// (R18) mode select: one code for timer/trigger/event, another for window
// (R19) oscillator stop forces start control to stop, clearing the counter
// (R20) new compare value loads on first source tick after upper byte write
// (R21) counter, compare A and capture B are 16 bits, read as bytes
// (R22) each match gives a one-cycle interrupt request pulse
//
// Decided for this implementation: register access over AHB-Lite and the register offsets.
module utw_timer (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        count_input_pin,
	input  wire logic        low_speed_tick,
	input  wire logic        low_frequency_run_mode,
	input  wire logic        low_frequency_sleep_mode,
	input  wire logic        osc_stop_entry,
	output logic             match_interrupt
);
	logic [8:0]               counter_control_register;
	logic [15:0]              compare_a_register;
	logic [15:0]              capture_b_register;
	logic [15:0]              counter;
	logic [7:0]               cmp_lo_stage;
	logic [7:0]               cmp_hi_stage;
	logic                     cmp_pending;
	logic                     wr_pend;
	logic [7:0]               wr_addr;
	utw_pkg::utw_state_t      state;
	utw_pkg::utw_state_t      next_state;
	logic [15:0]              next_count;
	logic                     next_match;
	logic                     tick_fc3;
	logic                     tick_fc7;
	logic                     tick_fc11;
	logic                     tick_fs3;
	logic                     pin_level;
	logic                     pin_rise;
	logic                     pin_fall;

	// control field decode
	wire [1:0] operating_mode_select = counter_control_register[utw_pkg::CTL_MODE_LSB +: 2];
	wire [1:0] source_clock_select   = counter_control_register[utw_pkg::CTL_CLK_LSB +: 2];
	wire [1:0] start_control         = counter_control_register[utw_pkg::CTL_START_LSB +: 2];
	wire       trigger_stop_select   = counter_control_register[utw_pkg::CTL_STOPSEL];
	wire       auto_capture_enable   = counter_control_register[utw_pkg::CTL_ACAP];
	wire       prescaler_select_bit  = counter_control_register[utw_pkg::CTL_PSEL];
	wire       low_freq              = low_frequency_run_mode || low_frequency_sleep_mode;

	// mode decode from mode, clock source and start fields
	wire ext_src   = source_clock_select == utw_pkg::CLK_PIN;
	wire base_mode = operating_mode_select == utw_pkg::MODE_BASE; // see (R18)
	wire win_mode  = operating_mode_select == utw_pkg::MODE_WINDOW; // see (R18)
	wire edge_arm  = start_control[1];
	wire is_timer  = base_mode && !ext_src && start_control == utw_pkg::START_CMD;
	wire is_trig   = base_mode && !ext_src && edge_arm;
	wire is_event  = base_mode && ext_src && edge_arm;
	wire is_window = win_mode && !ext_src && edge_arm;

	// pin edges: trigger or counting edge, and its opposite
	wire sel_rise  = start_control == utw_pkg::START_RISE;
	wire trig_edge = sel_rise ? pin_rise : pin_fall; // see (R5)
	wire opp_edge  = sel_rise ? pin_fall : pin_rise;
	wire gate_ok   = pin_level == sel_rise; // see (R15)

	// source clock select; high-speed taps are dead in low-frequency modes
	wire slow_div  = prescaler_select_bit || low_freq;
	wire src_tick  = (source_clock_select == utw_pkg::CLK_DIV11) ? (slow_div ? tick_fs3 : tick_fc11)
		: (source_clock_select == utw_pkg::CLK_DIV7) ? (tick_fc7 && !low_freq)
		: (source_clock_select == utw_pkg::CLK_DIV3) ? (tick_fc3 && !low_freq)
		: trig_edge; // see (R17) (R12)

	wire [15:0] inc     = counter + 16'h0001;
	wire        inc_hit = inc == compare_a_register;
	wire        running = state == utw_pkg::ST_RUN;

	// divider for the internal source clocks
	utw_prescaler u_prescaler (
		.hclk         (hclk),
		.hresetn      (hresetn),
		.slow_tick_in (low_speed_tick),
		.tick_fc3     (tick_fc3),
		.tick_fc7     (tick_fc7),
		.tick_fc11    (tick_fc11),
		.tick_fs3     (tick_fs3)
	);

	// pin synchroniser and noise filter, bypassed in low-frequency modes
	utw_pin_filter u_pin_filter (
		.hclk    (hclk),
		.hresetn (hresetn),
		.pin_in  (count_input_pin),
		.bypass  (low_freq), // see (R11)
		.level   (pin_level),
		.rise    (pin_rise),
		.fall    (pin_fall)
	);

	// counter sequencing
	always_comb
	begin
		next_state = state;
		next_count = counter;
		next_match = 1'b0;
		if (start_control == utw_pkg::START_STOP)
		begin
			next_state = utw_pkg::ST_IDLE;
			next_count = 16'h0000; // see (R19)
		end
		else
		begin
			case (state)
				utw_pkg::ST_IDLE:
				begin
					next_count = 16'h0000;
					if (is_timer || is_event || is_window)
						next_state = utw_pkg::ST_RUN;
					else if (is_trig)
						next_state = utw_pkg::ST_WAIT;
				end
				utw_pkg::ST_WAIT:
				begin
					if (!is_trig)
						next_state = utw_pkg::ST_IDLE;
					else if (trig_edge)
					begin
						next_state = utw_pkg::ST_RUN; // see (R5) (R8)
						next_count = 16'h0000;
					end
				end
				utw_pkg::ST_RUN:
				begin
					if (is_timer || is_window)
					begin
						if (src_tick && (is_timer || gate_ok)) // see (R15)
						begin
							next_count = inc_hit ? 16'h0000 : inc; // see (R1)
							next_match = inc_hit;
						end
					end
					else if (is_trig)
					begin
						if (src_tick && inc_hit)
						begin
							next_state = utw_pkg::ST_WAIT; // see (R6) (R9)
							next_count = 16'h0000;
							next_match = 1'b1;
						end
						else if (trigger_stop_select && opp_edge)
						begin
							next_state = utw_pkg::ST_WAIT; // see (R7)
							next_count = 16'h0000;
						end
						else if (src_tick)
							next_count = inc;
					end
					else if (is_event)
					begin
						if (opp_edge && counter == compare_a_register)
						begin
							next_count = 16'h0000; // see (R13)
							next_match = 1'b1;
						end
						else if (src_tick)
							next_count = inc; // see (R12)
					end
					else
						next_state = utw_pkg::ST_IDLE;
				end
				default:
					next_state = utw_pkg::ST_IDLE;
			endcase
		end
	end

	// state, count and one-cycle match pulse
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state           <= utw_pkg::ST_IDLE;
			counter         <= 16'h0000;
			match_interrupt <= 1'b0;
		end
		else
		begin
			state           <= next_state;
			counter         <= next_count;
			match_interrupt <= next_match; // see (R22)
		end
	end

	// auto-capture of the running count, only while running
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			capture_b_register <= 16'h0000;
		else if (src_tick && auto_capture_enable && running)
			capture_b_register <= counter; // see (R2) (R3) (R4) (R14)
	end

	// bus address phase decode
	wire ap_take  = hsel && htrans[1] && hready && hsize == 3'h2;
	wire wr_ctrl  = wr_pend && wr_addr == utw_pkg::OFF_CTRL;
	wire wr_cmplo = wr_pend && wr_addr == utw_pkg::OFF_CMP_LO;
	wire wr_cmphi = wr_pend && wr_addr == utw_pkg::OFF_CMP_HI;

	// read selection; unmapped offsets read zero
	wire [7:0]  ra     = haddr[7:0];
	wire [2:0]  status = {cmp_pending, state == utw_pkg::ST_WAIT, running};
	wire [31:0] rd_mux = (ra == utw_pkg::OFF_CTRL)   ? {23'h000000, counter_control_register}
		: (ra == utw_pkg::OFF_CMP_LO) ? {24'h000000, compare_a_register[7:0]}
		: (ra == utw_pkg::OFF_CMP_HI) ? {24'h000000, compare_a_register[15:8]}
		: (ra == utw_pkg::OFF_CAP_LO) ? {24'h000000, capture_b_register[7:0]}
		: (ra == utw_pkg::OFF_CAP_HI) ? {24'h000000, capture_b_register[15:8]}
		: (ra == utw_pkg::OFF_CNT_LO) ? {24'h000000, counter[7:0]}
		: (ra == utw_pkg::OFF_CNT_HI) ? {24'h000000, counter[15:8]}
		: (ra == utw_pkg::OFF_STATUS) ? {29'h00000000, status}
		: 32'h00000000; // see (R21)

	// bus slave: zero wait states, always OKAY
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend   <= 1'b0;
			wr_addr   <= 8'h00;
			hrdata    <= 32'h00000000;
			hreadyout <= 1'b0;
			hresp     <= 1'b0;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			wr_pend   <= ap_take && hwrite;
			wr_addr   <= ra;
			if (ap_take && !hwrite)
				hrdata <= rd_mux;
		end
	end

	// control register; oscillator stop overrides start control
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			counter_control_register <= utw_pkg::CTRL_RESET;
		else
		begin
			if (wr_ctrl)
				counter_control_register <= hwdata[utw_pkg::CTL_WIDTH-1:0];
			if (osc_stop_entry)
				counter_control_register[utw_pkg::CTL_START_LSB +: 2] <= utw_pkg::START_STOP; // see (R19)
		end
	end

	// compare staging: upper byte arms, next source tick loads
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cmp_lo_stage       <= utw_pkg::CMP_RESET[7:0];
			cmp_hi_stage       <= utw_pkg::CMP_RESET[15:8];
			cmp_pending        <= 1'b0;
			compare_a_register <= utw_pkg::CMP_RESET;
		end
		else
		begin
			if (src_tick && cmp_pending)
			begin
				compare_a_register <= {cmp_hi_stage, cmp_lo_stage}; // see (R20)
				cmp_pending        <= 1'b0;
			end
			if (wr_cmplo)
				cmp_lo_stage <= hwdata[7:0]; // see (R21)
			if (wr_cmphi)
			begin
				cmp_hi_stage <= hwdata[7:0];
				cmp_pending  <= 1'b1; // see (R20)
			end
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_timer_hit;
		running && is_timer && src_tick && inc_hit;
	endsequence
	sequence s_trig_hit;
		running && is_trig && src_tick && inc_hit;
	endsequence
	sequence s_trig_abort;
		running && is_trig && trigger_stop_select && opp_edge && !(src_tick && inc_hit);
	endsequence
	sequence s_cleared_halted;
		state == utw_pkg::ST_WAIT && counter == 16'h0000;
	endsequence

	timer_clear_a: assert property (s_timer_hit |=> counter == 16'h0000 && match_interrupt) // see (R1)
		else $error("timer match did not clear and interrupt");
	capture_copy_a: assert property ((src_tick && auto_capture_enable && running) // see (R2)
		|=> capture_b_register == $past(counter))
		else $error("capture register missed the running count");
	trig_start_a: assert property ((state == utw_pkg::ST_WAIT && is_trig && trig_edge) // see (R5)
		|=> running && counter == 16'h0000)
		else $error("trigger edge did not start the counter");
	trig_match_a: assert property (s_trig_hit |=> s_cleared_halted ##0 match_interrupt) // see (R6)
		else $error("trigger match did not halt with interrupt");
	trig_abort_a: assert property (s_trig_abort |=> s_cleared_halted ##0 !match_interrupt) // see (R7)
		else $error("opposite edge did not halt quietly");
	wait_hold_a: assert property ((state == utw_pkg::ST_WAIT && !trig_edge && is_trig) // see (R8)
		|=> $stable(counter) && !running)
		else $error("halted counter moved without trigger");
	event_match_a: assert property ((running && is_event && opp_edge // see (R13)
		&& counter == compare_a_register) |=> counter == 16'h0000 && match_interrupt)
		else $error("event match not taken on opposite edge");
	window_gate_a: assert property ((running && is_window && !gate_ok) // see (R15)
		|=> $stable(counter))
		else $error("window counted outside its gate");
	osc_stop_a: assert property (osc_stop_entry // see (R19)
		|=> start_control == utw_pkg::START_STOP ##1 counter == 16'h0000)
		else $error("oscillator stop did not stop the counter");
	cmp_load_a: assert property ($changed(compare_a_register) // see (R20)
		|-> $past(src_tick) && $past(cmp_pending))
		else $error("compare loaded without armed upper byte and tick");
	match_pulse_a: assert property (match_interrupt |=> !match_interrupt) // see (R22)
		else $error("match interrupt longer than one cycle");
endmodule : utw_timer

// ### sim/utw_pulse_src.sv
// pulse source model standing at the count input pin
module utw_pulse_src (
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic       go,
	input  wire logic [7:0] len,
	output logic            pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] left;
	// drives one high pulse of len cycles per go, idle low between pulses
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pin <= 1'b0;
			left <= 8'h00;
		end
		else if (go && left == 8'h00)
		begin
			pin <= 1'b1; // widths of 12 or more and 4 or less are asked for
			left <= len;
		end
		else if (left > 8'h01)
			left <= left - 8'h01;
		else if (left == 8'h01)
		begin
			pin <= 1'b0; // window pulses stay far slower than the tick
			left <= 8'h00;
		end
	end
endmodule : utw_pulse_src

// ### sim/tb_up_counter_timer_event_window.sv
// register level testbench of the up-counter timer
module tb_up_counter_timer_event_window;
	timeunit 1ns;
	timeprecision 1ps;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        match_interrupt;
	logic        pin;
	logic        slow_tick = 1'b0;
	logic        lf_run = 1'b0;
	logic        lf_sleep = 1'b0;
	logic        osc_stop = 1'b0;
	logic        go = 1'b0;
	logic [7:0]  plen = 8'h00;
	int          errors = 0;
	int          checks = 0;
	int          irq_cnt = 0;
	int          cyc = 0;
	int          base;
	int          t0;
	int          t1;
	logic [31:0] rd;
	// single slave: its ready is the bus ready
	wire logic   hready = hreadyout;
	utw_timer utw_timer_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .count_input_pin(pin),
		.low_speed_tick(slow_tick), .low_frequency_run_mode(lf_run),
		.low_frequency_sleep_mode(lf_sleep), .osc_stop_entry(osc_stop),
		.match_interrupt(match_interrupt));
	utw_pulse_src utw_pulse_src_inst (.hclk(hclk), .hresetn(hresetn), .go(go), .len(plen),
		.pin(pin));
	// clock of 40 ns period
	always #20 hclk = ~hclk;
	// cycle count, low-speed tick every 16 cycles, interrupt pulse tally
	always @(posedge hclk)
	begin
		cyc <= cyc + 1;
		slow_tick <= (cyc % 16 == 15);
		if (match_interrupt === 1'b1)
			irq_cnt <= irq_cnt + 1;
	end
	task automatic finish_test();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : finish_test
	task automatic check_val(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : check_val
	task automatic check_flag(input string nm, input logic ok);
		checks++;
		if (ok !== 1'b1)
		begin
			errors++;
			$display("MISMATCH %s expected 1 seen %b", nm, ok);
		end
	endtask : check_flag
	// waits for ready high at a rising edge, bounded
	task automatic wait_ready();
		int n;
		n = 0;
		do
		begin
			@(posedge hclk);
			n++;
		end
		while (hreadyout !== 1'b1 && n < 50);
		if (n >= 50)
		begin
			errors++;
			finish_test();
		end
	endtask : wait_ready
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= 3'h2;
		wait_ready();
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready();
		rd = hrdata;
		check_val("hresp", 32'h0, {31'h0, hresp});
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(a, 1'b1, d);
	endtask : wr
	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
		xfer(a, 1'b0, 32'h0);
		check_val(nm, e, rd);
	endtask : rd_chk
	function automatic logic [31:0] ctl(input logic [1:0] m, input logic [1:0] c,
		input logic [1:0] s, input logic t, input logic a);
		ctl = 32'h0;
		ctl[utw_pkg::CTL_MODE_LSB +: 2] = m;
		ctl[utw_pkg::CTL_CLK_LSB +: 2] = c;
		ctl[utw_pkg::CTL_START_LSB +: 2] = s;
		ctl[utw_pkg::CTL_STOPSEL] = t;
		ctl[utw_pkg::CTL_ACAP] = a;
	endfunction : ctl
	task automatic set_mode(input logic [1:0] m, input logic [1:0] c, input logic [1:0] s,
		input logic t, input logic a);
		wr(utw_pkg::OFF_CTRL, ctl(m, c, utw_pkg::START_STOP, 1'b0, 1'b0));
		wr(utw_pkg::OFF_CTRL, ctl(m, c, s, t, a));
	endtask : set_mode
	task automatic pulse(input logic [7:0] len, input int gap);
		go <= 1'b1;
		plen <= len;
		@(posedge hclk);
		go <= 1'b0;
		repeat (int'(len) + gap) @(posedge hclk);
	endtask : pulse
	task automatic wait_irq(output int at);
		int n;
		n = 0;
		do
		begin
			@(posedge hclk);
			n++;
		end
		while (match_interrupt !== 1'b1 && n < 1000);
		at = cyc;
		if (n >= 1000)
		begin
			errors++;
			finish_test();
		end
	endtask : wait_irq
	// main sequence
	initial
	begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		rd_chk("ctrl", utw_pkg::OFF_CTRL, 32'h0);
		rd_chk("cmp_lo", utw_pkg::OFF_CMP_LO, 32'h0000_00FF);
		rd_chk("cmp_hi", utw_pkg::OFF_CMP_HI, 32'h0000_00FF);
		rd_chk("cap_lo", utw_pkg::OFF_CAP_LO, 32'h0);
		rd_chk("cnt_hi", utw_pkg::OFF_CNT_HI, 32'h0);
		wr(8'h20, 32'h0000_00FF);
		rd_chk("unmapped", 8'h20, 32'h0);
		$display("test reset done");
		// stopped, but on a fast source clock so a staged compare value loads soon
		wr(utw_pkg::OFF_CTRL, ctl(utw_pkg::MODE_BASE, utw_pkg::CLK_DIV3, utw_pkg::START_STOP,
			1'b0, 1'b0));
		wr(utw_pkg::OFF_CMP_LO, 32'h3);
		repeat (20) @(posedge hclk);
		rd_chk("cmp_lo_only", utw_pkg::OFF_CMP_LO, 32'h0000_00FF);
		wr(utw_pkg::OFF_CMP_HI, 32'h0);
		repeat (20) @(posedge hclk);
		rd_chk("cmp_loaded", utw_pkg::OFF_CMP_LO, 32'h3);
		rd_chk("cmp_hi_loaded", utw_pkg::OFF_CMP_HI, 32'h0);
		$display("test compare done");
		set_mode(utw_pkg::MODE_BASE, utw_pkg::CLK_DIV3, utw_pkg::START_CMD, 1'b0, 1'b1);
		wait_irq(t0);
		@(posedge hclk);
		check_flag("irq_one_cycle", match_interrupt === 1'b0);
		wait_irq(t1);
		check_val("period", 32'd24, 32'(t1 - t0));
		xfer(utw_pkg::OFF_CAP_LO, 1'b0, 32'h0);
		check_flag("capture_range", rd <= 32'h2);
		osc_stop <= 1'b1;
		@(posedge hclk);
		osc_stop <= 1'b0;
		repeat (3) @(posedge hclk);
		rd_chk("stop_ctrl", utw_pkg::OFF_CTRL, ctl(utw_pkg::MODE_BASE, utw_pkg::CLK_DIV3,
			utw_pkg::START_STOP, 1'b0, 1'b1));
		rd_chk("stop_cnt", utw_pkg::OFF_CNT_LO, 32'h0);
		// slower internal sources: divide by 128, and the low-speed tick divided by 8
		set_mode(utw_pkg::MODE_BASE, utw_pkg::CLK_DIV7, utw_pkg::START_CMD, 1'b0, 1'b0);
		wait_irq(t0);
		wait_irq(t1);
		check_val("period_div7", 32'd384, 32'(t1 - t0));
		set_mode(utw_pkg::MODE_BASE, utw_pkg::CLK_DIV11, utw_pkg::START_STOP, 1'b0, 1'b0);
		wr(utw_pkg::OFF_CTRL, (32'h1 << utw_pkg::CTL_PSEL) | ctl(utw_pkg::MODE_BASE,
			utw_pkg::CLK_DIV11, utw_pkg::START_CMD, 1'b0, 1'b0));
		wait_irq(t0);
		wait_irq(t1);
		check_val("period_psel", 32'd384, 32'(t1 - t0));
		lf_sleep <= 1'b1;
		set_mode(utw_pkg::MODE_BASE, utw_pkg::CLK_DIV11, utw_pkg::START_CMD, 1'b0, 1'b0);
		wait_irq(t0);
		wait_irq(t1);
		check_val("period_sleep", 32'd384, 32'(t1 - t0));
		lf_sleep <= 1'b0;
		$display("test timer done");
		set_mode(utw_pkg::MODE_BASE, utw_pkg::CLK_DIV3, utw_pkg::START_RISE, 1'b1, 1'b0);
		base = irq_cnt;
		repeat (60) @(posedge hclk);
		rd_chk("no_trigger", utw_pkg::OFF_CNT_LO, 32'h0);
		pulse(8'd12, 40);
		rd_chk("early_stop_cnt", utw_pkg::OFF_CNT_LO, 32'h0);
		check_val("early_stop_irq", 32'(base), 32'(irq_cnt));
		pulse(8'd120, 40);
		check_val("match_irq", 32'(base + 1), 32'(irq_cnt));
		rd_chk("halt_cnt", utw_pkg::OFF_CNT_LO, 32'h0);
		rd_chk("halt_status", utw_pkg::OFF_STATUS, 32'h1 << utw_pkg::STS_WAIT);
		pulse(8'd120, 40);
		check_val("restart_irq", 32'(base + 2), 32'(irq_cnt));
		set_mode(utw_pkg::MODE_BASE, utw_pkg::CLK_DIV3, utw_pkg::START_RISE, 1'b0, 1'b0);
		pulse(8'd12, 60);
		check_val("start_only_irq", 32'(base + 3), 32'(irq_cnt));
		$display("test trigger done");
		set_mode(utw_pkg::MODE_BASE, utw_pkg::CLK_PIN, utw_pkg::START_RISE, 1'b0, 1'b0);
		base = irq_cnt;
		pulse(8'd4, 30);
		rd_chk("noise_cnt", utw_pkg::OFF_CNT_LO, 32'h0);
		repeat (3) pulse(8'd16, 16);
		check_val("event_irq", 32'(base + 1), 32'(irq_cnt));
		rd_chk("event_clear", utw_pkg::OFF_CNT_LO, 32'h0);
		lf_run <= 1'b1;
		pulse(8'd3, 20);
		rd_chk("bypass_cnt", utw_pkg::OFF_CNT_LO, 32'h1);
		lf_run <= 1'b0;
		$display("test event done");
		set_mode(utw_pkg::MODE_WINDOW, utw_pkg::CLK_DIV3, utw_pkg::START_RISE, 1'b0, 1'b0);
		base = irq_cnt;
		repeat (240) @(posedge hclk);
		check_val("window_closed", 32'(base), 32'(irq_cnt));
		pulse(8'd240, 20);
		check_flag("window_open", irq_cnt >= base + 9 && irq_cnt <= base + 11);
		// negative logic: counts while the idle-low pin stays low
		set_mode(utw_pkg::MODE_WINDOW, utw_pkg::CLK_DIV3, utw_pkg::START_FALL, 1'b0, 1'b0);
		base = irq_cnt;
		repeat (240) @(posedge hclk);
		check_flag("window_low", irq_cnt >= base + 9 && irq_cnt <= base + 11);
		$display("test window done");
		finish_test();
	end
endmodule : tb_up_counter_timer_event_window
